/* File: csic_core.v */
// Purpose: Register file ports, stack pointer, page select and interrupt entry/return
// Assumes: Decoder outside gives one-cycle strobes per executed instruction
// Notes: Interrupt sources arrive on the same clock as the core
`timescale 1ns/100ps
`include "csic_consts.vh"
// What this block does
// - Register file offers 8-bit and 16-bit read and write-back port schemes.
// - Working registers also answer at data addresses 0 to 31.
// - Top six registers form three 16-bit pointers with displacement, increment, decrement.
// - Stack grows downward; pointer marks the top, pushes lower it.
// - Byte push lowers pointer by one; call or interrupt push by two.
// - Byte pop raises pointer by one; return pops raise it by two.
// - Pointer is two I/O bytes at 3e and 3d; bits 15..13 read zero.
// - Reset pointer value is high 10, low ff.
// - Page bit selects program half for extended loads only.
// - Page register bits 7..1 read zero; software writes zeros.
// - Core runs straight on the clock, one instruction per clock.
// - Two-register ALU operations read, compute and write back in one cycle.
// - Source taken only when its enable and global enable are one.
// - Lower vector wins; reset first, external request zero next.
// - Vector select bit moves vectors to boot start; fuse moves reset.
// - Entry clears global enable; interrupt return sets it; software may nest.
// - Flags clear only on vectoring; pending flags wait.
// - Level sources request only while their condition holds.
// - After interrupt return one more instruction runs before next interrupt.
// - Clear-enable acts at once; set-enable lets one more instruction run.
// - Global enable is status bit 7; hardware and instructions control it.
// - Entry takes five cycles pushing return address, five more from sleep.
// - Interrupt return takes five cycles: pop, adjust pointer, set enable.
module csic_core #(
  parameter NUM_SRC = 8,
  parameter PC_WIDTH = 17,
  parameter [PC_WIDTH-1:0] BOOT_START = 17'h1f000
) (
  mclk,
  arst_n,
  io_addr,
  io_wr,
  io_rd,
  io_wdata,
  io_rdata,
  rd_a_addr,
  rd_a_data,
  rd_a_wide,
  rd_b_addr,
  rd_b_data,
  wr_en,
  wr_wide,
  wr_addr,
  wr_data,
  ds_en,
  ds_we,
  ds_addr,
  ds_wdata,
  ds_rdata,
  ptr_sel,
  ptr_mode,
  ptr_disp,
  ptr_addr,
  ptr_next,
  push_byte,
  pop_byte,
  push_ret,
  pop_ret,
  pc_in,
  sp_addr,
  stk_we,
  stk_wdata,
  stk_re,
  stk_rdata,
  ret_pc,
  ret_valid,
  xload,
  plain_load,
  z_in,
  prog_addr,
  instr_done,
  cmd_sei,
  cmd_cli,
  cmd_return_from_interrupt,
  sleeping,
  boot_reset_fuse,
  src_flag_set,
  src_level,
  src_is_level,
  src_enable,
  src_flag,
  irq_taken,
  irq_vector,
  reset_vector,
  cpu_stall,
  global_enable
);
  input wire mclk;
  input wire arst_n;
  input wire [5:0] io_addr;
  input wire io_wr;
  input wire io_rd;
  input wire [7:0] io_wdata;
  output reg [7:0] io_rdata;
  input wire [4:0] rd_a_addr;
  output wire [7:0] rd_a_data;
  output wire [15:0] rd_a_wide;
  input wire [4:0] rd_b_addr;
  output wire [7:0] rd_b_data;
  input wire wr_en;
  input wire wr_wide;
  input wire [4:0] wr_addr;
  input wire [15:0] wr_data;
  input wire ds_en;
  input wire ds_we;
  input wire [15:0] ds_addr;
  input wire [7:0] ds_wdata;
  output wire [7:0] ds_rdata;
  input wire [1:0] ptr_sel;
  input wire [1:0] ptr_mode;
  input wire [5:0] ptr_disp;
  output reg [15:0] ptr_addr;
  output reg [15:0] ptr_next;
  input wire push_byte;
  input wire pop_byte;
  input wire push_ret;
  input wire pop_ret;
  input wire [PC_WIDTH-1:0] pc_in;
  output wire [15:0] sp_addr;
  output reg stk_we;
  output reg [7:0] stk_wdata;
  output reg stk_re;
  input wire [7:0] stk_rdata;
  output reg [PC_WIDTH-1:0] ret_pc;
  output reg ret_valid;
  input wire xload;
  input wire plain_load;
  input wire [15:0] z_in;
  output wire [16:0] prog_addr;
  input wire instr_done;
  input wire cmd_sei;
  input wire cmd_cli;
  input wire cmd_return_from_interrupt;
  input wire sleeping;
  input wire boot_reset_fuse;
  input wire [NUM_SRC-1:0] src_flag_set;
  input wire [NUM_SRC-1:0] src_level;
  input wire [NUM_SRC-1:0] src_is_level;
  input wire [NUM_SRC-1:0] src_enable;
  output reg [NUM_SRC-1:0] src_flag;
  output reg irq_taken;
  output reg [PC_WIDTH-1:0] irq_vector;
  output wire [PC_WIDTH-1:0] reset_vector;
  output wire cpu_stall;
  output wire global_enable;
  localparam ST_RUN = 2'h0;
  localparam ST_ENTRY = 2'h1;
  localparam ST_RETURN = 2'h2;
  localparam [15:0] SP_RESET = {`CSIC_SPH_RESET, `CSIC_SPL_RESET};
  localparam [7:0] PAGE_RESET = `CSIC_PAGE_RESET;
  reg [1:0] state;
  reg [`CSIC_SP_WIDTH-1:0] sp;
  reg page_bit;
  reg [7:0] sreg;
  reg [7:0] mcu_control_register;
  reg [3:0] cnt;
  reg hold_one;
  reg [PC_WIDTH-1:0] save_pc;
  reg [$clog2(NUM_SRC)-1:0] win_idx;
  reg win_any;
  reg [$clog2(NUM_SRC)-1:0] take_idx;
  reg [NUM_SRC-1:0] req;
  reg [PC_WIDTH-1:0] next_ret_pc;
  integer k;
  wire rf_hit;
  wire [15:0] ptr_base;
  wire [15:0] ptr_x;
  wire [15:0] ptr_y;
  wire [15:0] ptr_z;
  wire [3:0] entry_len;
  assign rf_hit = ds_en && (ds_addr < `CSIC_RF_SPACE);
  csic_regfile u_rf (
    .mclk(mclk),
    .arst_n(arst_n),
    .rd_a_addr(rd_a_addr),
    .rd_a_data(rd_a_data),
    .rd_a_wide(rd_a_wide),
    .rd_b_addr(rd_b_addr),
    .rd_b_data(rd_b_data),
    .wr_en(wr_en),
    .wr_wide(wr_wide),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .ds_en(rf_hit),
    .ds_we(ds_we),
    .ds_addr(ds_addr[4:0]),
    .ds_wdata(ds_wdata),
    .ds_rdata(ds_rdata),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );
  // Pointer modes: 0 plain, 1 displacement, 2 post-increment, 3 pre-decrement
  assign ptr_base = (ptr_sel == 2'h0) ? ptr_x : (ptr_sel == 2'h1) ? ptr_y : ptr_z;
  always @* begin
    ptr_addr = ptr_base;
    ptr_next = ptr_base;
    case (ptr_mode)
      2'h1: ptr_addr = ptr_base + {10'h000, ptr_disp};
      2'h2: ptr_next = ptr_base + 16'h0001;
      2'h3: begin
        ptr_addr = ptr_base - 16'h0001;
        ptr_next = ptr_base - 16'h0001;
      end
      default: ptr_addr = ptr_base;
    endcase
  end
  assign sp_addr = {3'h0, sp};
  assign global_enable = sreg[`CSIC_GIE_BIT];
  assign prog_addr = xload ? {page_bit, z_in} : {1'b0, z_in};
  assign reset_vector = boot_reset_fuse ? BOOT_START : {PC_WIDTH{1'b0}};
  assign cpu_stall = (state != ST_RUN);
  assign entry_len = sleeping ? ({1'b0, `CSIC_ENTRY_CYCLES} + {1'b0, `CSIC_SLEEP_EXTRA}) : {1'b0, `CSIC_ENTRY_CYCLES};
  // Requests: flags latch, levels follow the condition
  always @* begin
    win_any = 1'b0;
    win_idx = {$clog2(NUM_SRC){1'b0}};
    for (k = 0; k < NUM_SRC; k = k + 1) begin
      req[k] = (src_is_level[k] ? src_level[k] : src_flag[k]) && src_enable[k];
    end
    for (k = NUM_SRC - 1; k >= 0; k = k - 1) begin
      if (req[k]) begin
        win_any = 1'b1;
        win_idx = k[$clog2(NUM_SRC)-1:0];
      end
    end
  end
  // Entry is allowed only at an instruction boundary, with enable still on after this cycle's clear
  wire take_now;
  assign take_now = (state == ST_RUN) && instr_done && win_any && sreg[`CSIC_GIE_BIT] && !cmd_cli && !hold_one;
  always @* begin
    io_rdata = 8'h00;
    case (io_addr)
      `CSIC_ADDR_SPL: io_rdata = sp[7:0];
      `CSIC_ADDR_SPH: io_rdata = {3'h0, sp[`CSIC_SP_WIDTH-1:8]};
      `CSIC_ADDR_PAGE: io_rdata = {7'h00, page_bit};
      `CSIC_ADDR_SREG: io_rdata = sreg;
      `CSIC_ADDR_MCU_CONTROL_REGISTER: io_rdata = mcu_control_register;
      default: io_rdata = 8'h00;
    endcase
  end
  always @* begin
    next_ret_pc = ret_pc;
    if (state == ST_RETURN && stk_re) begin
      next_ret_pc = {ret_pc[PC_WIDTH-9:0], stk_rdata};
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sp <= SP_RESET[`CSIC_SP_WIDTH-1:0];
      page_bit <= PAGE_RESET[0];
      sreg <= `CSIC_SREG_RESET;
      mcu_control_register <= 8'h00;
      state <= ST_RUN;
      cnt <= 4'h0;
      hold_one <= 1'b0;
      save_pc <= {PC_WIDTH{1'b0}};
      take_idx <= {$clog2(NUM_SRC){1'b0}};
      src_flag <= {NUM_SRC{1'b0}};
      irq_taken <= 1'b0;
      irq_vector <= {PC_WIDTH{1'b0}};
      ret_pc <= {PC_WIDTH{1'b0}};
      ret_valid <= 1'b0;
      stk_we <= 1'b0;
      stk_re <= 1'b0;
      stk_wdata <= 8'h00;
    end else begin
      irq_taken <= 1'b0;
      ret_valid <= 1'b0;
      stk_we <= 1'b0;
      stk_re <= 1'b0;
      ret_pc <= next_ret_pc;
      // Flags: set beats any clear in the same cycle
      for (k = 0; k < NUM_SRC; k = k + 1) begin
        if (src_flag_set[k] && !src_is_level[k]) begin
          src_flag[k] <= 1'b1;
        end else if (take_now && win_idx == k[$clog2(NUM_SRC)-1:0]) begin
          src_flag[k] <= 1'b0;
        end
      end
      if (io_wr && io_addr == `CSIC_ADDR_SPL) sp[7:0] <= io_wdata;
      else if (io_wr && io_addr == `CSIC_ADDR_SPH) sp[`CSIC_SP_WIDTH-1:8] <= io_wdata[4:0];
      else if (push_byte) sp <= sp - 13'h0001;
      else if (pop_byte) sp <= sp + 13'h0001;
      else if (push_ret) sp <= sp - 13'h0002;
      else if (pop_ret) sp <= sp + 13'h0002;
      if (io_wr && io_addr == `CSIC_ADDR_PAGE) page_bit <= io_wdata[0];
      if (io_wr && io_addr == `CSIC_ADDR_MCU_CONTROL_REGISTER) mcu_control_register <= io_wdata;
      if (io_wr && io_addr == `CSIC_ADDR_SREG) sreg <= io_wdata;
      if (cmd_cli) sreg[`CSIC_GIE_BIT] <= 1'b0;
      if (cmd_sei) sreg[`CSIC_GIE_BIT] <= 1'b1;
      if (instr_done && state == ST_RUN) hold_one <= cmd_sei;
      case (state)
        ST_RUN: begin
          if (take_now) begin
            state <= ST_ENTRY;
            cnt <= entry_len;
            save_pc <= pc_in;
            take_idx <= win_idx;
            sreg[`CSIC_GIE_BIT] <= 1'b0;
          end else if (cmd_return_from_interrupt) begin
            state <= ST_RETURN;
            cnt <= {1'b0, `CSIC_RETURN_CYCLES};
          end
        end
        ST_ENTRY: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h2 || cnt == 4'h3) begin
            stk_we <= 1'b1;
            stk_wdata <= (cnt == 4'h3) ? save_pc[7:0] : save_pc[15:8];
            sp <= sp - 13'h0001;
          end
          if (cnt == 4'h1) begin
            state <= ST_RUN;
            irq_taken <= 1'b1;
            irq_vector <= (mcu_control_register[`CSIC_VECTOR_SELECT_BIT_BIT] ? BOOT_START : {PC_WIDTH{1'b0}})
                          + {{(PC_WIDTH-$clog2(NUM_SRC)-1){1'b0}}, take_idx, 1'b0}
                          + {{(PC_WIDTH-2){1'b0}}, 2'h2};
          end
        end
        ST_RETURN: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h4 || cnt == 4'h3) begin
            stk_re <= 1'b1;
            sp <= sp + 13'h0001;
          end
          if (cnt == 4'h1) begin
            state <= ST_RUN;
            ret_valid <= 1'b1;
            sreg[`CSIC_GIE_BIT] <= 1'b1;
            hold_one <= 1'b1;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
endmodule // csic_core

/* File: csic_consts.vh */
// Purpose: Constants for the CPU stack and interrupt core
// Assumes: I/O addresses are 6-bit I/O space offsets
// Notes: Included by csic_core.v and csic_regfile.v
`ifndef CSIC_CONSTS_VH
`define CSIC_CONSTS_VH
`define CSIC_ADDR_PAGE 6'h3b
`define CSIC_ADDR_SPL 6'h3d
`define CSIC_ADDR_SPH 6'h3e
`define CSIC_ADDR_SREG 6'h3f
`define CSIC_ADDR_MCU_CONTROL_REGISTER 6'h35
`define CSIC_SPL_RESET 8'hff
`define CSIC_SPH_RESET 8'h10
`define CSIC_PAGE_RESET 8'h00
`define CSIC_SREG_RESET 8'h00
`define CSIC_SP_WIDTH 13
`define CSIC_GIE_BIT 7
`define CSIC_VECTOR_SELECT_BIT_BIT 1
`define CSIC_PTR_X 5'h1a
`define CSIC_PTR_Y 5'h1c
`define CSIC_PTR_Z 5'h1e
`define CSIC_ENTRY_CYCLES 3'h5
`define CSIC_SLEEP_EXTRA 3'h5
`define CSIC_RETURN_CYCLES 3'h5
`define CSIC_RF_SPACE 16'h0020
`endif

/* File: csic_regfile.v */
// Purpose: 32 x 8-bit working register file with 8/16-bit ports
// Assumes: Writes land on the clock edge; reads are combinational
// Notes: Write port is 16-bit to an even pair when wide
`timescale 1ns/100ps
`include "csic_consts.vh"
module csic_regfile (
  mclk,
  arst_n,
  rd_a_addr,
  rd_a_data,
  rd_a_wide,
  rd_b_addr,
  rd_b_data,
  wr_en,
  wr_wide,
  wr_addr,
  wr_data,
  ds_en,
  ds_we,
  ds_addr,
  ds_wdata,
  ds_rdata,
  ptr_x,
  ptr_y,
  ptr_z
);
  input wire mclk;
  input wire arst_n;
  input wire [4:0] rd_a_addr;
  output wire [7:0] rd_a_data;
  output wire [15:0] rd_a_wide;
  input wire [4:0] rd_b_addr;
  output wire [7:0] rd_b_data;
  input wire wr_en;
  input wire wr_wide;
  input wire [4:0] wr_addr;
  input wire [15:0] wr_data;
  input wire ds_en;
  input wire ds_we;
  input wire [4:0] ds_addr;
  input wire [7:0] ds_wdata;
  output wire [7:0] ds_rdata;
  output wire [15:0] ptr_x;
  output wire [15:0] ptr_y;
  output wire [15:0] ptr_z;
  reg [7:0] regs [0:31];
  integer i;
  wire [4:0] pair_lo;
  assign pair_lo = {rd_a_addr[4:1], 1'b0};
  assign rd_a_data = regs[rd_a_addr];
  assign rd_b_data = regs[rd_b_addr];
  assign rd_a_wide = {regs[pair_lo + 5'h01], regs[pair_lo]};
  assign ds_rdata = regs[ds_addr];
  assign ptr_x = {regs[`CSIC_PTR_X + 5'h01], regs[`CSIC_PTR_X]};
  assign ptr_y = {regs[`CSIC_PTR_Y + 5'h01], regs[`CSIC_PTR_Y]};
  assign ptr_z = {regs[`CSIC_PTR_Z + 5'h01], regs[`CSIC_PTR_Z]};
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs[i] <= 8'h00;
      end
    end else begin
      if (wr_en && wr_wide) begin
        regs[{wr_addr[4:1], 1'b0}] <= wr_data[7:0];
        regs[{wr_addr[4:1], 1'b1}] <= wr_data[15:8];
      end else if (wr_en) begin
        regs[wr_addr] <= wr_data[7:0];
      end else if (ds_en && ds_we) begin
        regs[ds_addr] <= ds_wdata;
      end
    end
  end
endmodule // csic_regfile

/* File: csic_props.sv */
// Purpose: Port checks for csic_core
// Assumes: One clock, async low reset
// Notes: Bound to every csic_core instance
`timescale 1ns/100ps
module csic_props #(
  parameter PC_WIDTH = 17,
  parameter [PC_WIDTH-1:0] BOOT_START = 17'h1f000
) (
  input wire mclk,
  input wire arst_n,
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire [7:0] io_rdata,
  input wire push_byte,
  input wire pop_byte,
  input wire push_ret,
  input wire pop_ret,
  input wire [15:0] sp_addr,
  input wire stk_we,
  input wire ret_valid,
  input wire xload,
  input wire [15:0] z_in,
  input wire [16:0] prog_addr,
  input wire cmd_cli,
  input wire cmd_return_from_interrupt,
  input wire boot_reset_fuse,
  input wire irq_taken,
  input wire [PC_WIDTH-1:0] reset_vector,
  input wire global_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_byte_push;
    push_byte && !io_wr;
  endsequence
  sequence s_ret_pop;
    pop_ret && !io_wr && !push_byte && !pop_byte && !push_ret;
  endsequence
  sequence s_ret_end;
    ret_valid ##1 global_enable;
  endsequence
  AST_PUSH_BYTE: assert property (s_byte_push |=> sp_addr == $past(sp_addr) - 16'h0001)
    else $error("byte push did not lower pointer by one");
  AST_POP_RET: assert property (s_ret_pop |=> sp_addr == $past(sp_addr) + 16'h0002)
    else $error("return pop did not raise pointer by two");
  AST_SPH_READ: assert property (io_addr == 6'h3e |-> io_rdata == {3'h0, sp_addr[12:8]})
    else $error("pointer high byte read wrong");
  AST_PAGE_READ: assert property (io_addr == 6'h3b |-> io_rdata[7:1] == 7'h00)
    else $error("page register upper bits not zero");
  AST_PLAIN_LOAD: assert property (!xload |-> prog_addr == {1'b0, z_in})
    else $error("plain load used page bit");
  AST_CLI_BLOCK: assert property (cmd_cli |-> ##6 !irq_taken)
    else $error("interrupt taken at clear-enable");
  AST_ENTRY: assert property (irq_taken |-> !global_enable && $past(stk_we, 1) && $past(stk_we, 2))
    else $error("entry did not push two bytes or clear enable");
  AST_RETURN: assert property (cmd_return_from_interrupt |-> ##6 s_ret_end)
    else $error("return timing or enable wrong");
  AST_BOOT_RESET: assert property (boot_reset_fuse |-> reset_vector == BOOT_START)
    else $error("reset vector not at boot start");
endmodule // csic_props
bind csic_core csic_props #(.PC_WIDTH(PC_WIDTH), .BOOT_START(BOOT_START)) props_u (
  .mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rdata(io_rdata),
  .push_byte(push_byte), .pop_byte(pop_byte), .push_ret(push_ret), .pop_ret(pop_ret),
  .sp_addr(sp_addr), .stk_we(stk_we), .ret_valid(ret_valid), .xload(xload), .z_in(z_in),
  .prog_addr(prog_addr), .cmd_cli(cmd_cli), .cmd_return_from_interrupt(cmd_return_from_interrupt), .boot_reset_fuse(boot_reset_fuse),
  .irq_taken(irq_taken), .reset_vector(reset_vector), .global_enable(global_enable));

/* File: csic_stack_mem.sv */
// Purpose: Stack area of data memory
// Assumes: Read data is used in the cycle the read strobe is high
// Notes: Released bus shows the inverse of the last byte
`timescale 1ns/100ps
module csic_stack_mem (
  input wire mclk,
  input wire stk_we,
  input wire [7:0] stk_wdata,
  input wire stk_re,
  output wire [7:0] stk_rdata
);
  logic [7:0] mem [0:15];
  logic [3:0] top = 4'h0;
  logic [7:0] last = 8'h00;
  always @(posedge mclk) begin
    if (stk_we) begin
      mem[top] <= stk_wdata;
      top <= top + 4'h1;
    end else if (stk_re) begin
      last <= mem[top - 4'h1];
      top <= top - 4'h1;
    end
  end
  assign stk_rdata = stk_re ? mem[top - 4'h1] : ~last;
endmodule // csic_stack_mem

/* File: cpu_stack_interrupt_core_tb.sv */
// Purpose: Self-checking bench for csic_core
// Assumes: Inputs change at the falling edge
// Notes: Table rows first, interrupt cases after
`timescale 1ns/100ps
module cpu_stack_interrupt_core_tb;
  typedef struct {logic k; logic [5:0] a; logic [7:0] d; logic [15:0] e;} csic_row_t;
  csic_row_t rows [0:8];
  logic mclk = 0, arst_n = 0, io_wr = 0, wr_en = 0, wr_wide = 0, ds_en = 0, xload = 0, sleeping = 0;
  logic push_byte = 0, pop_byte = 0, push_ret = 0, pop_ret = 0, cmd_sei = 0, cmd_cli = 0, cmd_return_from_interrupt = 0;
  logic fuse = 0, io_rd = 0, ds_we = 0, plain_load = 0, instr_done = 1;
  logic [5:0] io_addr = 0, ptr_disp = 0;
  logic [7:0] io_wdata = 0, ds_wdata = 0, io_rdata, rd_a_data, rd_b_data, ds_rdata, stk_wdata, stk_rdata;
  logic [7:0] sfs = 0, slv = 0, sil = 0, sen = 0, src_flag;
  logic [4:0] rd_a_addr = 0, rd_b_addr = 0, wr_addr = 0;
  logic [15:0] wr_data = 0, ds_addr = 0, z_in = 0, rd_a_wide, ptr_addr, ptr_next, sp_addr;
  logic [1:0] ptr_sel = 0, ptr_mode = 0;
  logic [16:0] pc_in = 17'h0abcd, ret_pc, irq_vector, reset_vector, prog_addr;
  logic stk_we, stk_re, ret_valid, irq_taken, cpu_stall, global_enable;
  int fail_count = 0, cmp_count = 0, cyc = 0, n1, n2, irqs = 0, i;
  csic_core dut_u (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .rd_a_addr(rd_a_addr), .rd_a_data(rd_a_data), .rd_a_wide(rd_a_wide),
    .rd_b_addr(rd_b_addr), .rd_b_data(rd_b_data), .wr_en(wr_en), .wr_wide(wr_wide), .wr_addr(wr_addr),
    .wr_data(wr_data), .ds_en(ds_en), .ds_we(ds_we), .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata),
    .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr), .ptr_next(ptr_next),
    .push_byte(push_byte), .pop_byte(pop_byte), .push_ret(push_ret), .pop_ret(pop_ret), .pc_in(pc_in),
    .sp_addr(sp_addr), .stk_we(stk_we), .stk_wdata(stk_wdata), .stk_re(stk_re), .stk_rdata(stk_rdata),
    .ret_pc(ret_pc), .ret_valid(ret_valid), .xload(xload), .plain_load(plain_load), .z_in(z_in),
    .prog_addr(prog_addr), .instr_done(instr_done), .cmd_sei(cmd_sei), .cmd_cli(cmd_cli), .cmd_return_from_interrupt(cmd_return_from_interrupt),
    .sleeping(sleeping), .boot_reset_fuse(fuse), .src_flag_set(sfs), .src_level(slv), .src_is_level(sil),
    .src_enable(sen), .src_flag(src_flag), .irq_taken(irq_taken), .irq_vector(irq_vector),
    .reset_vector(reset_vector), .cpu_stall(cpu_stall), .global_enable(global_enable));
  csic_stack_mem mem_u (.mclk(mclk), .stk_we(stk_we), .stk_wdata(stk_wdata), .stk_re(stk_re), .stk_rdata(stk_rdata));
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (irq_taken === 1'b1) irqs++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    @(negedge mclk);
    io_wr = 0;
  endtask
  task automatic sp_op(input logic [3:0] o);
    @(negedge mclk);
    {push_byte, pop_byte, push_ret, pop_ret} = o;
    @(negedge mclk);
    {push_byte, pop_byte, push_ret, pop_ret} = 4'h0;
  endtask
  task automatic pulse_sei(output int n);
    @(negedge mclk);
    cmd_sei = 1;
    @(negedge mclk);
    cmd_sei = 0;
    n = 0;
    while (irq_taken !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
  endtask
  initial begin
    rows = '{'{0, 6'h3d, 8'h00, 16'h0}, '{0, 6'h3e, 8'hff, 16'h1f}, '{0, 6'h3e, 8'h10, 16'h10},
      '{0, 6'h3b, 8'hff, 16'h1}, '{0, 6'h3b, 8'h00, 16'h0}, '{1, 0, 8'h8, 16'h0fff},
      '{1, 0, 8'h2, 16'h0ffd}, '{1, 0, 8'h1, 16'h0fff}, '{1, 0, 8'h4, 16'h1000}};
    repeat (8) @(negedge mclk);
    arst_n = 1;
    chk(sp_addr, 17'h010ff);
    chk(global_enable, 0);
    for (i = 0; i < 9; i++) begin
      if (rows[i].k) sp_op(rows[i].d[3:0]);
      else io_w(rows[i].a, rows[i].d);
      io_addr = rows[i].a;
      #1 chk(rows[i].k ? sp_addr : io_rdata, rows[i].e);
    end
    io_w(6'h3b, 8'h01);
    z_in = 16'h1234;
    xload = 1;
    #1 chk(prog_addr, 17'h11234);
    fuse = 1;
    #1 chk(reset_vector, 17'h1f000);
    @(negedge mclk);
    wr_en = 1;
    wr_wide = 1;
    wr_addr = 5'h1a;
    wr_data = 16'h0abc;
    @(negedge mclk);
    wr_wide = 0;
    wr_addr = 5'h05;
    wr_data = 16'h003c;
    @(negedge mclk);
    wr_en = 0;
    rd_a_addr = 5'h1a;
    rd_b_addr = 5'h05;
    ds_en = 1;
    ds_addr = 16'h001b;
    ptr_mode = 2;
    #1 chk(rd_a_wide, 17'h0abc);
    chk(rd_a_data, 17'h00bc);
    chk(rd_b_data, 17'h3c);
    chk(ds_rdata, 17'h0a);
    chk(ptr_next, 17'h0abd);
    ptr_mode = 3;
    #1 chk(ptr_next, 17'h0abb);
    chk(ptr_addr, 17'h0abb);
    ptr_mode = 1;
    ptr_disp = 6'h05;
    #1 chk(ptr_addr, 17'h0ac1);
    ptr_sel = 2;
    #1 chk(ptr_addr, 17'h00005);
    @(negedge mclk);
    ds_we = 1;
    ds_addr = 16'h0005;
    ds_wdata = 8'h5a;
    @(negedge mclk);
    ds_addr = 16'h0025;
    ds_wdata = 8'ha5;
    @(negedge mclk);
    ds_we = 0;
    chk(rd_b_data, 17'h5a);
    sen = 8'h2e;
    sfs = 8'h29;
    @(negedge mclk);
    sfs = 0;
    repeat (3) @(negedge mclk);
    chk(src_flag, 17'h29);
    chk(irqs, 0);
    pulse_sei(n1);
    chk(irq_vector, 17'h00008);
    chk(src_flag, 17'h21);
    io_w(6'h35, 8'h02);
    sleeping = 1;
    pulse_sei(n2);
    sleeping = 0;
    chk(irq_vector, 17'h1f00c);
    chk(n2 - n1, 5);
    chk(sp_addr, 17'h0ffc);
    @(negedge mclk);
    cmd_return_from_interrupt = 1;
    @(negedge mclk);
    cmd_return_from_interrupt = 0;
    repeat (6) @(negedge mclk);
    chk(ret_pc[15:0], 17'habcd);
    chk(global_enable, 1);
    chk(sp_addr, 17'h0ffe);
    @(negedge mclk);
    cmd_cli = 1;
    sfs = 8'h04;
    sil = 8'h02;
    slv = 8'h02;
    @(negedge mclk);
    cmd_cli = 0;
    sfs = 0;
    repeat (3) @(negedge mclk);
    slv = 0;
    repeat (10) @(negedge mclk);
    chk(irqs, 2);
    pulse_sei(n1);
    chk(irq_vector, 17'h1f006);
    @(negedge mclk);
    cmd_return_from_interrupt = 1;
    slv = 8'h02;
    @(negedge mclk);
    cmd_return_from_interrupt = 0;
    chk(cpu_stall, 1);
    repeat (11) @(negedge mclk);
    chk(irq_taken, 0);
    @(negedge mclk);
    chk(irq_taken, 1);
    chk(irq_vector, 17'h1f004);
    instr_done = 0;
    io_w(6'h3f, 8'h80);
    repeat (8) @(negedge mclk);
    chk(irqs, 4);
    chk(cpu_stall, 0);
    instr_done = 1;
    repeat (6) @(negedge mclk);
    chk(irq_taken, 1);
    @(negedge mclk);
    arst_n = 0;
    #1 chk(sp_addr, 17'h010ff);
    chk(src_flag, 17'h00);
    @(negedge mclk);
    arst_n = 1;
    io_addr = 6'h3b;
    #1 chk(io_rdata, 17'h00);
    chk(global_enable, 0);
    @(negedge mclk);
    chk(irq_taken, 0);
    end_sim();
  end
endmodule // cpu_stack_interrupt_core_tb
